// [core/rcch_map.vh]
`ifndef RCCH_MAP_VH
`define RCCH_MAP_VH
// Summary of operation
// - table transfer carries one whole 1609-byte block
// - block is 8-byte header, 1600 bytes, delimiter
// - table query returns same 1609-byte layout
// - identity is query-only, four fields in order
// - identity serial reads 0, version holds both revisions
// - clear empties buffers, zeroes status and events
// - reset clears as clear, plus enables, talk/listen
// - operation-complete sets event status bit 0
// - service request when SRE allows the ESE-masked event summary or the unmasked reply-pending bit
// - operation-complete query answers character 1
// - wait command accepted, does nothing, no delay
// - address command selects local unit, 1 to 30
// - absent unit address raises no error
// - local address defaults to 1, master unit

// register byte offsets
`define RC_CMD     8'h00
`define RC_STAT    8'h04
`define RC_RXD     8'h08
`define RC_TXD     8'h0C
`define RC_ESR     8'h10
`define RC_ESE     8'h14
`define RC_SRE     8'h18
`define RC_STB     8'h1C
`define RC_IRQST   8'h20
`define RC_IRQMSK  8'h24
`define RC_LBADDR  8'h28
`define RC_LAST    8'h28

// command codes written to the command register
`define RC_OP_CLS  4'h1
`define RC_OP_RST  4'h2
`define RC_OP_OPC  4'h3
`define RC_OP_OPCQ 4'h4
`define RC_OP_WAI  4'h5
`define RC_OP_IDNQ 4'h6
`define RC_OP_DL   4'h7
`define RC_OP_ULQ  4'h8

// block layout and reply lengths
`define RC_BLK_LAST  11'h648
`define RC_HDR_LEN   11'h008
`define RC_HDR_STR   64'h2336303031363030
`define RC_LF        8'h0A
`define RC_IDN_LAST  11'h011
`define RC_OPCQ_LAST 11'h001
`define RC_CHAR_ONE  8'h31

// local bus address
`define RC_LB_DEF  5'h01
`define RC_LB_MIN  5'h01
`define RC_LB_MAX  5'h1E

// event bits of the interrupt status and event status registers
`define RC_EV_OPC   0
`define RC_EV_DLOK  1
`define RC_EV_DLERR 2
`define RC_EV_SRQ   3
`define RC_ESR_OPC  0

`define RC_RESP_OK  2'h0
`define RC_RESP_ERR 2'h2
`endif

// [core/rcch_top.v]
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "rcch_map.vh"
module rcch_top #(
  parameter [31:0] MAKER_ID = "VNDR", // arbitrary value
  parameter [31:0] MODEL_ID = "UNIT", // arbitrary value
  parameter [15:0] HW_REV   = "A1",   // arbitrary value
  parameter [15:0] SW_REV   = "B2"    // arbitrary value
)(
  input  wire        clk_sys,
  input  wire        rst,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  output wire [4:0]  lbAddr,
  output wire        irq
);

  //****************************************
  // constants and state codes
  //****************************************
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_DL   = 5'h02;
  localparam [4:0] ST_UP   = 5'h04;
  localparam [4:0] ST_IDN  = 5'h08;
  localparam [4:0] ST_OPCQ = 5'h10;
  localparam [8*18-1:0] IDN_STR = {MAKER_ID, 8'h2C, MODEL_ID, 8'h2C, 8'h30, 8'h2C,
                                   HW_REV, 8'h2F, SW_REV, `RC_LF};

  //****************************************
  // functions
  //****************************************
  function isMapped;
    input [7:0] a;
    begin
      isMapped = (a[1:0] == 2'h0) && (a <= `RC_LAST);
    end
  endfunction

  function [7:0] hdrChar;
    input [10:0] idx;
    reg   [63:0] sh;
    begin
      sh      = `RC_HDR_STR >> {3'h7 - idx[2:0], 3'h0};
      hdrChar = sh[7:0];
    end
  endfunction

  //****************************************
  // registers
  //****************************************
  reg        awReady_ff;
  reg        wReady_ff;
  reg        awHave_ff;
  reg        wHave_ff;
  reg [7:0]  wAddr_ff;
  reg [7:0]  wData_ff;
  reg        wLane0_ff;
  reg        bValid_ff;
  reg [1:0]  bResp_ff;
  reg        arReady_ff;
  reg        rValid_ff;
  reg [1:0]  rResp_ff;
  reg [31:0] rData_ff;
  reg [4:0]  state_ff;
  reg [10:0] cnt_ff;
  reg        tableOk_ff;
  reg [7:0]  esr_ff;
  reg [7:0]  ese_ff;
  reg [7:0]  sre_ff;
  reg [3:0]  irqSt_ff;
  reg [3:0]  irqMask_ff;
  reg        irq_ff;
  reg        mssPrev_ff;
  reg [4:0]  lbAddr_ff;
  reg [7:0]  tableMem [0:1599];

  assign s_axi_awready = awReady_ff;
  assign s_axi_wready  = wReady_ff;
  assign s_axi_bvalid  = bValid_ff;
  assign s_axi_bresp   = bResp_ff;
  assign s_axi_arready = arReady_ff;
  assign s_axi_rvalid  = rValid_ff;
  assign s_axi_rresp   = rResp_ff;
  assign s_axi_rdata   = rData_ff;
  assign lbAddr        = lbAddr_ff;
  assign irq           = irq_ff;

  //****************************************
  // decode
  //****************************************
  wire        wrExec   = awHave_ff && wHave_ff && !bValid_ff;
  wire        wrOk     = wrExec && wLane0_ff && isMapped(wAddr_ff);
  wire        rdExec   = s_axi_arvalid && arReady_ff;
  wire        cmdExec  = wrOk && (wAddr_ff == `RC_CMD);
  wire [3:0]  cmdCode  = wData_ff[3:0];
  wire        doCls    = cmdExec && (cmdCode == `RC_OP_CLS || cmdCode == `RC_OP_RST);
  wire        doRst    = cmdExec && (cmdCode == `RC_OP_RST);
  wire        doOpc    = cmdExec && (cmdCode == `RC_OP_OPC);
  wire        rxExec   = wrOk && (wAddr_ff == `RC_RXD) && (state_ff == ST_DL);
  wire        replyOn  = (state_ff == ST_UP) || (state_ff == ST_IDN) || (state_ff == ST_OPCQ);
  wire        popEn    = rdExec && (s_axi_araddr == `RC_TXD) && replyOn && !cmdExec;
  wire        inData   = (cnt_ff >= `RC_HDR_LEN) && (cnt_ff < `RC_BLK_LAST);
  wire [10:0] memIdx   = cnt_ff - `RC_HDR_LEN;
  wire [143:0] idnShift = IDN_STR >> {(`RC_IDN_LAST - cnt_ff), 3'h0};
  wire        memWe    = rxExec && inData;
  wire        hdrBad   = rxExec && (cnt_ff < `RC_HDR_LEN) && (wData_ff != hdrChar(cnt_ff));
  wire        endByte  = rxExec && (cnt_ff == `RC_BLK_LAST);
  wire        dlGood   = endByte && (wData_ff == `RC_LF);
  wire        dlBad    = hdrBad || (endByte && (wData_ff != `RC_LF));

  // status byte and service request summary
  wire        esb      = |(esr_ff & ese_ff);
  wire [7:0]  stbLow   = {2'h0, esb, replyOn, 4'h0};
  wire        mss      = |(stbLow & sre_ff);
  wire [7:0]  stb      = stbLow | {1'b0, mss, 6'h00};

  //****************************************
  // reply byte source
  //****************************************
  reg [7:0]  txByte;
  reg        replyLast;
  always @*
  begin
    txByte    = 8'h00;
    replyLast = 1'b0;
    case (state_ff)
      ST_UP:
      begin
        if (cnt_ff < `RC_HDR_LEN)
          txByte = hdrChar(cnt_ff);
        else if (cnt_ff == `RC_BLK_LAST)
          txByte = `RC_LF;
        else
          txByte = tableMem[memIdx];
        replyLast = (cnt_ff == `RC_BLK_LAST);
      end
      ST_IDN:
      begin
        txByte    = idnShift[7:0];
        replyLast = (cnt_ff == `RC_IDN_LAST);
      end
      ST_OPCQ:
      begin
        txByte    = (cnt_ff == 11'h000) ? `RC_CHAR_ONE : `RC_LF;
        replyLast = (cnt_ff == `RC_OPCQ_LAST);
      end
      default:
      begin
        txByte    = 8'h00;
        replyLast = 1'b0;
      end
    endcase
  end

  //****************************************
  // read mux
  //****************************************
  reg [31:0] rdMux;
  always @*
  begin
    rdMux = 32'h0000_0000;
    case (s_axi_araddr)
      `RC_STAT:   rdMux = {24'h0, lbAddr_ff, replyOn, (state_ff == ST_DL), tableOk_ff};
      `RC_TXD:    rdMux = {23'h0, replyOn, txByte};
      `RC_ESR:    rdMux = {24'h0, esr_ff};
      `RC_ESE:    rdMux = {24'h0, ese_ff};
      `RC_SRE:    rdMux = {24'h0, sre_ff};
      `RC_STB:    rdMux = {24'h0, stb};
      `RC_IRQST:  rdMux = {28'h0, irqSt_ff};
      `RC_IRQMSK: rdMux = {28'h0, irqMask_ff};
      `RC_LBADDR: rdMux = {27'h0, lbAddr_ff};
      default:    rdMux = 32'h0000_0000;
    endcase
  end

  //****************************************
  // table memory
  //****************************************
  always @(posedge clk_sys)
  begin
    if (memWe)
      tableMem[memIdx] <= wData_ff;
  end

  //****************************************
  // bus channels
  //****************************************
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      awReady_ff <= 1'b1;
      wReady_ff  <= 1'b1;
      awHave_ff  <= 1'b0;
      wHave_ff   <= 1'b0;
      wAddr_ff   <= 8'h00;
      wData_ff   <= 8'h00;
      wLane0_ff  <= 1'b0;
      bValid_ff  <= 1'b0;
      bResp_ff   <= `RC_RESP_OK;
      arReady_ff <= 1'b1;
      rValid_ff  <= 1'b0;
      rResp_ff   <= `RC_RESP_OK;
      rData_ff   <= 32'h0000_0000;
    end
    else
    begin
      if (s_axi_awvalid && awReady_ff)
      begin
        wAddr_ff   <= s_axi_awaddr;
        awHave_ff  <= 1'b1;
        awReady_ff <= 1'b0;
      end
      if (s_axi_wvalid && wReady_ff)
      begin
        wData_ff  <= s_axi_wdata[7:0];
        wLane0_ff <= s_axi_wstrb[0];
        wHave_ff  <= 1'b1;
        wReady_ff <= 1'b0;
      end
      if (wrExec)
      begin
        awHave_ff <= 1'b0;
        wHave_ff  <= 1'b0;
        bValid_ff <= 1'b1;
        bResp_ff  <= isMapped(wAddr_ff) ? `RC_RESP_OK : `RC_RESP_ERR;
      end
      else if (bValid_ff && s_axi_bready)
      begin
        bValid_ff  <= 1'b0;
        awReady_ff <= 1'b1;
        wReady_ff  <= 1'b1;
      end
      if (rdExec)
      begin
        rData_ff   <= rdMux;
        rResp_ff   <= isMapped(s_axi_araddr) ? `RC_RESP_OK : `RC_RESP_ERR;
        rValid_ff  <= 1'b1;
        arReady_ff <= 1'b0;
      end
      else if (rValid_ff && s_axi_rready)
      begin
        rValid_ff  <= 1'b0;
        arReady_ff <= 1'b1;
      end
    end
  end

  //****************************************
  // command engine
  //****************************************
  reg [3:0] evSet;
  always @*
  begin
    evSet = 4'h0;
    evSet[`RC_EV_OPC]   = doOpc;
    evSet[`RC_EV_DLOK]  = dlGood;
    evSet[`RC_EV_DLERR] = dlBad;
    evSet[`RC_EV_SRQ]   = mss && !mssPrev_ff;
  end

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_ff   <= ST_IDLE;
      cnt_ff     <= 11'h000;
      tableOk_ff <= 1'b0;
      esr_ff     <= 8'h00;
      ese_ff     <= 8'h00;
      sre_ff     <= 8'h00;
      irqSt_ff   <= 4'h0;
      irqMask_ff <= 4'h0;
      irq_ff     <= 1'b0;
      mssPrev_ff <= 1'b0;
      lbAddr_ff  <= `RC_LB_DEF;
    end
    else
    begin
      mssPrev_ff <= mss;
      irq_ff     <= |(irqSt_ff & irqMask_ff);
      if (wrOk && wAddr_ff == `RC_IRQST)
        irqSt_ff <= (irqSt_ff & ~wData_ff[3:0]) | evSet;
      else
        irqSt_ff <= irqSt_ff | evSet;
      if (wrOk && wAddr_ff == `RC_IRQMSK)
        irqMask_ff <= wData_ff[3:0];
      if (wrOk && wAddr_ff == `RC_ESE)
        ese_ff <= wData_ff;
      if (wrOk && wAddr_ff == `RC_SRE)
        sre_ff <= wData_ff;
      // values outside 1..30 are dropped; an empty slot is no error
      if (wrOk && wAddr_ff == `RC_LBADDR && wData_ff[7:5] == 3'h0 &&
          wData_ff[4:0] >= `RC_LB_MIN && wData_ff[4:0] <= `RC_LB_MAX)
        lbAddr_ff <= wData_ff[4:0];
      if (doOpc)
        esr_ff[`RC_ESR_OPC] <= 1'b1;
      if (doCls)
      begin
        esr_ff   <= 8'h00;
        state_ff <= ST_IDLE;
        cnt_ff   <= 11'h000;
      end
      if (doRst)
      begin
        ese_ff <= 8'h00;
        sre_ff <= 8'h00;
      end
      if (cmdExec)
      begin
        if (cmdCode != `RC_OP_WAI && cmdCode != `RC_OP_OPC)
          cnt_ff <= 11'h000;
        case (cmdCode)
          `RC_OP_DL:
          begin
            state_ff   <= ST_DL;
            tableOk_ff <= 1'b0;
          end
          `RC_OP_ULQ:  state_ff <= ST_UP;
          `RC_OP_IDNQ: state_ff <= ST_IDN;
          `RC_OP_OPCQ: state_ff <= ST_OPCQ;
          `RC_OP_WAI:  state_ff <= state_ff;
          `RC_OP_OPC:  state_ff <= state_ff;
          default:     state_ff <= ST_IDLE;
        endcase
      end
      else if (rxExec)
      begin
        cnt_ff <= cnt_ff + 11'h001;
        if (dlBad)
          state_ff <= ST_IDLE;
        else if (dlGood)
        begin
          state_ff   <= ST_IDLE;
          tableOk_ff <= 1'b1;
        end
      end
      else if (popEn)
      begin
        cnt_ff <= cnt_ff + 11'h001;
        if (replyLast)
          state_ff <= ST_IDLE;
      end
    end
  end

endmodule

// [dv/rcch_sva.sv]
`timescale 1ns/1ps
`include "rcch_map.vh"
module rcch_sva (
  input wire        clk_sys,
  input wire        rst,
  input wire        s_axi_awready,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire [4:0]  lbAddr,
  input wire        irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_lbRange; lbAddr >= `RC_LB_MIN && lbAddr <= `RC_LB_MAX; endproperty
  a_lbRange: assert property (p_lbRange) else $error("local address out of range");
  property p_lbDef; $fell(rst) |-> lbAddr == `RC_LB_DEF; endproperty
  a_lbDef: assert property (p_lbDef) else $error("local address not 1 after reset");
  property p_lbHold; $changed(lbAddr) |-> $past(!s_axi_awready); endproperty
  a_lbHold: assert property (p_lbHold) else $error("local address moved without a write");
  property p_bStand; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bStand: assert property (p_bStand) else $error("write response dropped early");
  property p_bHold; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_bHold: assert property (p_bHold) else $error("write channels ready during response");
  property p_rLat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rLat: assert property (p_rLat) else $error("read answer late");
  property p_rStand; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rStand: assert property (p_rStand) else $error("read data dropped early");
  property p_rDone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready; endproperty
  a_rDone: assert property (p_rDone) else $error("read not closed");
  property p_rErr;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > `RC_LAST |=> s_axi_rresp == `RC_RESP_ERR && s_axi_rdata == 32'h0;
  endproperty
  a_rErr: assert property (p_rErr) else $error("unmapped read not refused");
  c_irq: cover property (irq);
  c_lbTop: cover property (lbAddr == `RC_LB_MAX);
  c_wErr: cover property (s_axi_bvalid && s_axi_bresp == `RC_RESP_ERR);
endmodule
bind rcch_top rcch_sva u_sva (.*);

// [dv/rcch_host.sv]
`timescale 1ns/1ps
module rcch_host (
  input  wire        clk_sys,
  output reg  [7:0]  s_axi_awaddr = 8'h00,
  output reg         s_axi_awvalid = 1'b0,
  input  wire        s_axi_awready,
  output reg  [31:0] s_axi_wdata = 32'h0,
  output reg  [3:0]  s_axi_wstrb = 4'h0,
  output reg         s_axi_wvalid = 1'b0,
  input  wire        s_axi_wready,
  input  wire        s_axi_bvalid,
  output reg         s_axi_bready = 1'b0,
  output reg  [7:0]  s_axi_araddr = 8'h00,
  output reg         s_axi_arvalid = 1'b0,
  input  wire        s_axi_arready,
  input  wire        s_axi_rvalid,
  output reg         s_axi_rready = 1'b0
);
  // released lines show the inverse of the last value
  // ready for the answer is raised n cycles late so that answers must stand
  task wr(input [7:0] a, input [31:0] d, input [1:0] n);
    @(posedge clk_sys);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hF};
    {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
      if (s_axi_wvalid && s_axi_wready) {s_axi_wvalid, s_axi_wdata, s_axi_wstrb} <= {1'b0, ~d, 4'h0};
    end
    while (s_axi_awvalid || s_axi_wvalid);
    repeat (n) @(posedge clk_sys);
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
    end
    while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
  endtask
  task rd(input [7:0] a, input [1:0] n);
    @(posedge clk_sys);
    {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
    do
    begin
      @(posedge clk_sys);
    end
    while (!(s_axi_arvalid && s_axi_arready));
    {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
    repeat (n) @(posedge clk_sys);
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
    end
    while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
  endtask
endmodule

// [dv/tb_top.sv]
`timescale 1ns/1ps
`include "rcch_map.vh"
module tb_top;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] seed = 32'hB74EB937;
  wire  [7:0]  s_axi_awaddr, s_axi_araddr;
  wire  [31:0] s_axi_wdata, s_axi_rdata;
  wire  [3:0]  s_axi_wstrb;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  wire         s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  wire  [4:0]  lbAddr;
  logic [1:0]  qB [$];
  logic [33:0] qR [$];
  logic [7:0]  tbl [1600];
  int          mismatches = 0;
  int          samplesChecked = 0;
  string       hdr = "#6001600";
  string       idn = "VNDR,UNIT,0,A1/B2";
  rcch_host u_host (.*);
  rcch_top #(.MAKER_ID("VNDR"), .MODEL_ID("UNIT"), .HW_REV("A1"), .SW_REV("B2")) u_rcch_top (.*);
  always #5 clk_sys = ~clk_sys;
  function automatic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task tally(input bad, input [33:0] e, input [33:0] g);
    samplesChecked++;
    if (bad)
    begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task cmpResp(input [1:0] e, input [1:0] g);
    tally(g !== e, {32'h0, e}, {32'h0, g});
  endtask
  task cmpRead(input [33:0] e, input [33:0] g);
    tally(g !== e, e, g);
  endtask
  task cmpIrq(input e, input g);
    tally(g !== e, {33'h0, e}, {33'h0, g});
  endtask
  task cmpLb(input [4:0] e, input [4:0] g);
    tally(g !== e, {29'h0, e}, {29'h0, g});
  endtask
  task w(input [7:0] a, input [31:0] d, input [1:0] e = `RC_RESP_OK);
    qB.push_back(e);
    u_host.wr(a, d, 2'(rnd()));
  endtask
  task r(input [7:0] a, input [31:0] d, input [1:0] e = `RC_RESP_OK);
    qR.push_back({e, d});
    u_host.rd(a, 2'(rnd()));
  endtask
  task rb(input [7:0] b);
    r(`RC_TXD, {23'h0, 1'b1, b});
  endtask
  task irqChk(input b);
    repeat (3) @(posedge clk_sys);
    cmpIrq(b, irq);
  endtask
  task lbChk(input [4:0] e);
    @(posedge clk_sys);
    cmpLb(e, lbAddr);
  endtask
  task sendBlk(input [7:0] last);
    w(`RC_CMD, `RC_OP_DL);
    for (int i = 0; i < 8; i++) w(`RC_RXD, {24'h0, hdr[i]});
    for (int i = 0; i < 1600; i++) w(`RC_RXD, {24'h0, tbl[i]});
    w(`RC_RXD, {24'h0, last});
  endtask
  task conclude;
    $display("checked %0d mismatches %0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    if (s_axi_bvalid && s_axi_bready) cmpResp(qB.pop_front(), s_axi_bresp);
    if (s_axi_rvalid && s_axi_rready) cmpRead(qR.pop_front(), {s_axi_rresp, s_axi_rdata});
  end
  initial
  begin
    #500000;
    mismatches++;
    conclude;
  end
  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    r(`RC_LBADDR, 32'h1);
    r(`RC_STAT, 32'h8);
    lbChk(5'h01);
    $display("test reset done");
    w(`RC_LBADDR, 32'h1E);
    r(`RC_LBADDR, 32'h1E);
    lbChk(5'h1E);
    w(`RC_LBADDR, 32'h1F);
    w(`RC_LBADDR, 32'h0);
    r(`RC_LBADDR, 32'h1E);
    lbChk(5'h1E);
    w(`RC_LBADDR, 32'h3);
    w(`RC_CMD, `RC_OP_CLS);
    w(`RC_CMD, `RC_OP_RST);
    r(`RC_LBADDR, 32'h3);
    lbChk(5'h03);
    w(`RC_LBADDR, 32'h1);
    lbChk(5'h01);
    w(8'h2C, 32'h1, `RC_RESP_ERR);
    w(8'h02, 32'h1, `RC_RESP_ERR);
    r(8'h2C, 32'h0, `RC_RESP_ERR);
    r(`RC_LBADDR, 32'h1);
    $display("test address done");
    w(`RC_IRQMSK, 32'hF);
    w(`RC_ESE, 32'h1);
    w(`RC_SRE, 32'h20);
    w(`RC_CMD, `RC_OP_OPC);
    r(`RC_ESR, 32'h1);
    r(`RC_STB, 32'h60);
    r(`RC_IRQST, 32'h9);
    irqChk(1'b1);
    w(`RC_IRQST, 32'hF);
    irqChk(1'b0);
    w(`RC_CMD, `RC_OP_WAI);
    r(`RC_ESR, 32'h1);
    w(`RC_CMD, `RC_OP_CLS);
    r(`RC_ESR, 32'h0);
    r(`RC_STB, 32'h0);
    w(`RC_CMD, `RC_OP_RST);
    r(`RC_ESE, 32'h0);
    r(`RC_SRE, 32'h0);
    w(`RC_IRQMSK, 32'h0);
    w(`RC_CMD, `RC_OP_OPC);
    irqChk(1'b0);
    r(`RC_IRQST, 32'h1);
    w(`RC_IRQST, 32'h1);
    $display("test events done");
    w(`RC_CMD, `RC_OP_OPCQ);
    rb(`RC_CHAR_ONE);
    w(`RC_CMD, `RC_OP_WAI);
    rb(`RC_LF);
    r(`RC_TXD, 32'h0);
    w(`RC_CMD, `RC_OP_IDNQ);
    for (int i = 0; i < 17; i++) rb(idn[i]);
    rb(`RC_LF);
    w(`RC_CMD, `RC_OP_OPCQ);
    w(`RC_CMD, `RC_OP_CLS);
    r(`RC_TXD, 32'h0);
    $display("test replies done");
    for (int i = 0; i < 1600; i++) tbl[i] = 8'(rnd());
    sendBlk(`RC_LF);
    r(`RC_STAT, 32'h9);
    r(`RC_IRQST, 32'h2);
    w(`RC_CMD, `RC_OP_ULQ);
    for (int i = 0; i < 8; i++) rb(hdr[i]);
    for (int i = 0; i < 1600; i++) rb(tbl[i]);
    rb(`RC_LF);
    sendBlk(8'h00);
    r(`RC_STAT, 32'h8);
    r(`RC_IRQST, 32'h6);
    $display("test table done");
    repeat (4) @(posedge clk_sys);
    conclude;
  end
endmodule
